// ===== hpw_pkg.sv
package hpw_pkg;

    // ****************************************
    // Register index values on the host port.
    // ****************************************
    localparam logic [5:0] IDX_OUT_IRQ  = 6'h06;
    localparam logic [5:0] IDX_PTR      = 6'h07;
    localparam logic [5:0] IDX_DATA     = 6'h08;
    localparam logic [5:0] IDX_GATE     = 6'h09;
    localparam logic [5:0] IDX_MEMCMD   = 6'h04;

    // ****************************************
    // CPU-side register byte offsets.
    // ****************************************
    localparam logic [7:0] CPU_OUT_IRQ  = 8'h00;
    localparam logic [7:0] CPU_PTR      = 8'h04;
    localparam logic [7:0] CPU_DATA     = 8'h08;
    localparam logic [7:0] CPU_GATE     = 8'h0C;

    // ****************************************
    // Field layout and constants.
    // ****************************************
    localparam int          PTR_HI      = 9;
    localparam int          PTR_LO      = 2;
    localparam int          OUT_IRQ_W   = 8;
    localparam logic [7:0]  GATE_KEY    = 8'hA5;
    localparam logic [7:0]  PTR_STEP    = 8'h01;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam int          CMD_STEPDIR = 0;
    localparam int          CMD_READ    = 3;
    localparam int          CMD_WRITE   = 5;
    localparam int          CMD_HOLD    = 6;
    localparam int          RAM_WORDS   = 256;

    typedef logic [5:0] hpw_idx_t;

endpackage : hpw_pkg

// ===== hpw_if.sv
`timescale 1ns/1ps
interface hpw_if;
    import hpw_pkg::*;
    hpw_idx_t    register_index;      // Register index field, set by host.
    logic        register_select_n;   // Register select pin, active low.
    logic        wr;                  // Host write strobe.
    logic        rd;                  // Host read strobe.
    logic [31:0] wdata;               // Host write data.
    logic [31:0] rdata;               // Device read data, one cycle later.
    logic        host_irq_pin;        // Outbound interrupt to host.

    modport dev  (input register_index, register_select_n, wr, rd, wdata, output rdata, host_irq_pin);
    modport host (output register_index, register_select_n, wr, rd, wdata, input rdata, host_irq_pin);
endinterface : hpw_if

// ===== hpw_ram.sv
`timescale 1ns/1ps
module hpw_ram #(
    parameter int WORDS = hpw_pkg::RAM_WORDS,
    parameter int AW    = 8
) (
    input  wire logic          sys_clk_i,   // System clock.
    input  wire logic          a_we_i,      // Port A write.
    input  wire logic [AW-1:0] a_addr_i,    // Port A word address.
    input  wire logic [31:0]   a_wdata_i,   // Port A write data.
    output logic      [31:0]   a_rdata_o,   // Port A read data.
    input  wire logic          b_we_i,      // Port B write.
    input  wire logic [AW-1:0] b_addr_i,    // Port B word address.
    input  wire logic [31:0]   b_wdata_i,   // Port B write data.
    output logic      [31:0]   b_rdata_o    // Port B read data.
);
    logic [31:0] mem [WORDS];

    // Two synchronous ports; same-word writes in one cycle let port B win.
    always_ff @(posedge sys_clk_i) begin
        if (a_we_i) begin
            mem[a_addr_i] <= a_wdata_i;
        end
        if (b_we_i) begin
            mem[b_addr_i] <= b_wdata_i;
        end
        a_rdata_o <= mem[a_addr_i];
        b_rdata_o <= mem[b_addr_i];
    end
endmodule : hpw_ram

// ===== hpw_device.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module hpw_device (
    input  wire logic        sys_clk_i,      // System clock, 20 MHz.
    input  wire logic        rst_i,          // Asynchronous reset, active high.
    hpw_if.dev               hp,             // Host port.
    input  wire logic        boot_mode_i,    // Host boot strap, sampled after reset.
    input  wire logic [7:0]  cpu_addr_i,     // CPU register byte address.
    input  wire logic [31:0] cpu_wdata_i,    // CPU write data.
    input  wire logic        cpu_wr_i,       // CPU register write strobe.
    input  wire logic        cpu_rd_i,       // CPU register read strobe.
    output logic      [31:0] cpu_rdata_o,    // CPU read data, one cycle later.
    input  wire logic        cpu_ram_req_i,  // CPU shared RAM request.
    input  wire logic        cpu_ram_we_i,   // CPU shared RAM write.
    input  wire logic [7:0]  cpu_ram_addr_i, // CPU shared RAM word address.
    input  wire logic [31:0] cpu_ram_wdata_i,// CPU shared RAM write data.
    output logic      [31:0] cpu_ram_rdata_o,// CPU shared RAM read data.
    output logic             cpu_wait_o,     // CPU stalled by gate.
    output logic             cpu_boot_go_o   // Pulse: start CPU from shared RAM.
);
    import hpw_pkg::*;

    // ****************************************
    // Storage.
    // ****************************************
    logic [OUT_IRQ_W-1:0] out_irq_r;
    logic [7:0]           ptr_r;
    logic [7:0]           ptr_nxt;
    logic [31:0]          data_r;
    logic                 gate_r;
    logic                 boot_armed_r;
    logic                 strap_done_r;
    logic                 cmd_rd_r;
    logic                 cmd_wr_r;
    logic                 hold_r;
    logic                 dir_r;
    logic                 fetch_r;
    logic                 ram_wr_pend_r;
    logic                 rd_step_r;
    logic                 rd_step;
    logic [31:0]          ram_a_rdata;
    logic [31:0]          ram_b_rdata;
    logic                 sel_ok;
    logic                 h_wr;
    logic                 h_rd;
    logic                 cpu_ram_go;

    assign sel_ok     = !hp.register_select_n;
    assign h_wr       = hp.wr && sel_ok;
    assign h_rd       = hp.rd && sel_ok;
    assign cpu_ram_go = cpu_ram_req_i && !gate_r;
    // A held read steps the pointer first, so its fetch reads the following word.
    assign rd_step    = hold_r && cmd_rd_r && h_rd && hp.register_index == IDX_DATA;

    // Step pointer one word, wrapping inside the eight-bit field.
    assign ptr_nxt = dir_r ? ptr_r - PTR_STEP : ptr_r + PTR_STEP;

    // ****************************************
    // Outbound interrupt control.
    // ****************************************
    // Host write wins a same-cycle collision with the CPU, like a bus arbiter would.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_irq_r <= '0;
        end else if (h_wr && hp.register_index == IDX_OUT_IRQ) begin
            out_irq_r <= hp.wdata[OUT_IRQ_W-1:0];
        end else if (cpu_wr_i && cpu_addr_i == CPU_OUT_IRQ) begin
            out_irq_r <= cpu_wdata_i[OUT_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hp.host_irq_pin <= 1'b0;
        end else begin
            hp.host_irq_pin <= out_irq_r[0];
        end
    end

    // ****************************************
    // Memory command bits, host only.
    // ****************************************
    // A single read or write clears its command once the transfer is issued.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_rd_r <= 1'b0;
            cmd_wr_r <= 1'b0;
            hold_r   <= 1'b0;
            dir_r    <= 1'b0;
        end else if (h_wr && hp.register_index == IDX_MEMCMD) begin
            cmd_rd_r <= hp.wdata[CMD_READ];
            cmd_wr_r <= hp.wdata[CMD_WRITE];
            hold_r   <= hp.wdata[CMD_HOLD];
            dir_r    <= hp.wdata[CMD_STEPDIR];
        end else if (!hold_r) begin
            cmd_rd_r <= 1'b0;
            cmd_wr_r <= 1'b0;
        end
    end

    // ****************************************
    // Transfer sequencing.
    // ****************************************
    // One-shot read fetches at once; in hold mode each data read or write is a transfer.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_r       <= 1'b0;
            ram_wr_pend_r <= 1'b0;
            rd_step_r     <= 1'b0;
        end else begin
            rd_step_r <= rd_step;
            fetch_r <= (cmd_rd_r && !hold_r) || rd_step_r;
            ram_wr_pend_r <= (cmd_wr_r && !hold_r)
                       || (hold_r && cmd_wr_r && h_wr && hp.register_index == IDX_DATA);
        end
    end

    // ****************************************
    // Word pointer.
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_r <= '0;
        end else if (h_wr && hp.register_index == IDX_PTR) begin
            ptr_r <= hp.wdata[PTR_HI:PTR_LO];
        end else if ((hold_r && ram_wr_pend_r) || rd_step) begin
            ptr_r <= ptr_nxt;
        end
    end

    // ****************************************
    // Data word and mailbox.
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_r <= '0;
        end else if (fetch_r) begin
            data_r <= ram_a_rdata;
        end else if (h_wr && hp.register_index == IDX_DATA) begin
            data_r <= hp.wdata;
        end else if (cpu_wr_i && cpu_addr_i == CPU_DATA) begin
            data_r <= cpu_wdata_i;
        end
    end

    // ****************************************
    // Access gate.
    // ****************************************
    // Reset forces zero; the strap is caught by the first clocked edge after release.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_r       <= 1'b0;
            strap_done_r <= 1'b0;
            boot_armed_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            gate_r       <= boot_mode_i;
            boot_armed_r <= boot_mode_i;
        end else if (h_wr && hp.register_index == IDX_GATE) begin
            if (!hp.wdata[0]) begin
                gate_r <= 1'b0;
            end else if (hp.wdata[7:0] == GATE_KEY) begin
                gate_r <= 1'b1;
            end
        end
        else if (!gate_r) begin
            boot_armed_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_boot_go_o <= 1'b0;
            cpu_wait_o    <= 1'b0;
        end else begin
            cpu_boot_go_o <= boot_armed_r && strap_done_r && !gate_r;
            cpu_wait_o    <= cpu_ram_req_i && gate_r;
        end
    end

    // ****************************************
    // Shared RAM for the device-side bank.
    // ****************************************
    hpw_ram u_ram (
        .sys_clk_i (sys_clk_i),
        .a_we_i    (ram_wr_pend_r),
        .a_addr_i  (ptr_r),
        .a_wdata_i (data_r),
        .a_rdata_o (ram_a_rdata),
        .b_we_i    (cpu_ram_go && cpu_ram_we_i),
        .b_addr_i  (cpu_ram_addr_i),
        .b_wdata_i (cpu_ram_wdata_i),
        .b_rdata_o (ram_b_rdata)
    );

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_ram_rdata_o <= '0;
        end else begin
            cpu_ram_rdata_o <= ram_b_rdata;
        end
    end

    // ****************************************
    // Read ports.
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hp.rdata <= '0;
        end else begin
            unique case (hp.register_index)
                IDX_OUT_IRQ: hp.rdata <= {24'h000000, out_irq_r};
                IDX_PTR:     hp.rdata <= {22'h000000, ptr_r, 2'h0};
                IDX_DATA:    hp.rdata <= data_r;
                IDX_GATE:    hp.rdata <= {31'h00000000, gate_r};
                default:     hp.rdata <= ZERO_WORD;
            endcase
        end
    end

    // CPU writes to the pointer and gate fall through: they are read-only there.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_rdata_o <= '0;
        end else if (cpu_rd_i) begin
            unique case (cpu_addr_i)
                CPU_OUT_IRQ: cpu_rdata_o <= {24'h000000, out_irq_r};
                CPU_PTR:     cpu_rdata_o <= {22'h000000, ptr_r, 2'h0};
                CPU_DATA:    cpu_rdata_o <= data_r;
                CPU_GATE:    cpu_rdata_o <= {31'h00000000, gate_r};
                default:     cpu_rdata_o <= ZERO_WORD;
            endcase
        end else begin
            cpu_rdata_o <= ZERO_WORD;
        end
    end
endmodule : hpw_device

// ===== hpw_host.sv
`timescale 1ns/1ps
module hpw_host (
    input  wire logic             sys_clk_i, // System clock.
    input  wire logic             rst_i,     // Asynchronous reset, active high.
    hpw_if.host                   hp,        // Host port.
    input  wire hpw_pkg::hpw_idx_t u_idx_i,  // Register index for the access.
    input  wire logic [31:0]      u_wdata_i, // Write data.
    input  wire logic             u_wr_i,    // Write request pulse.
    input  wire logic             u_rd_i,    // Read request pulse.
    output logic      [31:0]      u_rdata_o, // Read data, three cycles after request.
    output logic                  u_valid_o, // Read data valid pulse.
    output logic                  u_irq_o    // Interrupt from device, resampled.
);
    import hpw_pkg::*;

    logic rd_d_r;
    logic irq_s1_r;
    logic irq_s2_r;
    logic irq_s3_r;

    // ****************************************
    // Drive the port.
    // ****************************************
    // Index and select are set with the strobe so every access is addressed.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hp.register_index    <= '0;
            hp.register_select_n <= 1'b1;
            hp.wr                <= 1'b0;
            hp.rd                <= 1'b0;
            hp.wdata             <= '0;
        end else begin
            hp.register_index    <= u_idx_i;
            hp.register_select_n <= !(u_wr_i || u_rd_i);
            hp.wr                <= u_wr_i;
            hp.rd                <= u_rd_i && !u_wr_i;
            hp.wdata             <= u_wdata_i;
        end
    end

    // Read data lands one cycle after the strobe reaches the device.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_d_r    <= 1'b0;
            u_valid_o <= 1'b0;
            u_rdata_o <= '0;
        end else begin
            rd_d_r    <= hp.rd;
            u_valid_o <= rd_d_r;
            u_rdata_o <= rd_d_r ? hp.rdata : u_rdata_o;
        end
    end

    // Interrupt is a pin from outside: three stages, and a change counts once the last two agree.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_s3_r <= 1'b0;
            u_irq_o  <= 1'b0;
        end else begin
            irq_s1_r <= hp.host_irq_pin;
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
            if (irq_s2_r == irq_s3_r) begin
                u_irq_o <= irq_s3_r;
            end
        end
    end
endmodule : hpw_host

// ===== hpw_sva.sv
`timescale 1ns/1ps
// ****************************************
// Host port protocol checks.
// ****************************************
module hpw_sva (
    input wire logic             sys_clk_i,         // System clock.
    input wire logic             rst_i,             // Asynchronous reset, active high.
    input wire hpw_pkg::hpw_idx_t register_index,   // Register index from the host.
    input wire logic             register_select_n, // Register select, active low.
    input wire logic             wr,                // Host write strobe.
    input wire logic             rd,                // Host read strobe.
    input wire logic [31:0]      wdata,             // Host write data.
    input wire logic [31:0]      rdata,             // Device read data.
    input wire logic             host_irq_pin       // Interrupt to the host.
);
    import hpw_pkg::*;
    logic [31:0] wd_r;
    logic        hw;
    logic        hr;
    // Keep the last host write word, so that a read straight after it can be judged.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_r <= ZERO_WORD;
        end else if (wr) begin
            wd_r <= wdata;
        end
    end
    // Only strobes with the select low count as accesses.
    assign hw = wr && !register_select_n;
    assign hr = rd && !register_select_n;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_irq_upper_zero: assert property (hr && register_index == IDX_OUT_IRQ |=> rdata[31:8] == 24'h0)
        else $error("interrupt register upper bits not zero");
    a_irq_read_back: assert property ((hw && register_index == IDX_OUT_IRQ) ##1 (hr && register_index == IDX_OUT_IRQ)
        |=> rdata == {24'h0, wd_r[7:0]})
        else $error("interrupt register read back wrong");
    a_irq_pin_set: assert property (hw && register_index == IDX_OUT_IRQ && wdata[0] |-> ##2 host_irq_pin)
        else $error("interrupt pin not raised");
    a_irq_pin_clear: assert property (hw && register_index == IDX_OUT_IRQ && !wdata[0] |-> ##2 !host_irq_pin)
        else $error("interrupt pin not dropped");
    a_ptr_zero_bits: assert property (hr && register_index == IDX_PTR |=> rdata[31:10] == 22'h0 && rdata[1:0] == 2'h0)
        else $error("pointer reserved bits not zero");
    a_ptr_load: assert property ((hw && register_index == IDX_PTR) ##1 (hr && register_index == IDX_PTR)
        |=> rdata == {22'h0, wd_r[9:2], 2'h0})
        else $error("pointer not loaded by host");
    a_gate_zero_bits: assert property (hr && register_index == IDX_GATE |=> rdata[31:1] == 31'h0)
        else $error("gate register key bits not zero");
    a_gate_key_set: assert property ((hw && register_index == IDX_GATE && wdata[7:0] == GATE_KEY)
        ##1 (hr && register_index == IDX_GATE) |=> rdata[0])
        else $error("gate not set by key write");
    a_gate_clear: assert property ((hw && register_index == IDX_GATE && !wdata[0])
        ##1 (hr && register_index == IDX_GATE) |=> !rdata[0])
        else $error("gate not cleared by host");
    c_key_write: cover property (hw && register_index == IDX_GATE && wdata[7:0] == GATE_KEY);
    c_irq_raised: cover property (host_irq_pin);
    c_mem_cmd: cover property (hw && register_index == IDX_MEMCMD);
    c_back_to_back: cover property (hw ##1 hr);
endmodule : hpw_sva

// ===== hpw_test.sv
`timescale 1ns/1ps
// ****************************************
// Bench joining host and device ends.
// ****************************************
module hpw_test;
    import hpw_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        boot_mode_i = 1'b0;
    hpw_idx_t    u_idx_i = 6'h00;
    logic [31:0] u_wdata_i = 32'h0;
    logic        u_wr_i = 1'b0;
    logic        u_rd_i = 1'b0;
    logic [31:0] u_rdata_o;
    logic        u_valid_o;
    logic        u_irq_o;
    logic [7:0]  cpu_addr_i = 8'h00;
    logic [7:0]  cpu_ram_addr_i = 8'h00;
    logic [31:0] cpu_wdata_i = 32'h0;
    logic [31:0] cpu_ram_wdata_i = 32'h0;
    logic        cpu_wr_i = 1'b0;
    logic        cpu_rd_i = 1'b0;
    logic        cpu_ram_req_i = 1'b0;
    logic        cpu_ram_we_i = 1'b0;
    logic [31:0] cpu_rdata_o;
    logic [31:0] cpu_ram_rdata_o;
    logic        cpu_wait_o;
    logic        cpu_boot_go_o;
    logic [31:0] q;
    int          k;
    int          checks = 0;
    int          mismatches = 0;
    hpw_if bus ();
    hpw_host i_hpw_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hp(bus), .u_idx_i(u_idx_i), .u_wdata_i(u_wdata_i),
        .u_wr_i(u_wr_i), .u_rd_i(u_rd_i), .u_rdata_o(u_rdata_o), .u_valid_o(u_valid_o), .u_irq_o(u_irq_o));
    hpw_device i_hpw_device (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hp(bus), .boot_mode_i(boot_mode_i),
        .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
        .cpu_rdata_o(cpu_rdata_o), .cpu_ram_req_i(cpu_ram_req_i), .cpu_ram_we_i(cpu_ram_we_i),
        .cpu_ram_addr_i(cpu_ram_addr_i), .cpu_ram_wdata_i(cpu_ram_wdata_i), .cpu_ram_rdata_o(cpu_ram_rdata_o),
        .cpu_wait_o(cpu_wait_o), .cpu_boot_go_o(cpu_boot_go_o));
    hpw_sva i_hpw_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .register_index(bus.register_index),
        .register_select_n(bus.register_select_n), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
        .rdata(bus.rdata), .host_irq_pin(bus.host_irq_pin));
    // Free-running 20 MHz clock.
    always #25 sys_clk_i = ~sys_clk_i;

    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // A lost handshake ends the run at once, since later steps would only cascade.
    task fail(input string what);
        mismatches++;
        $display("ERROR %s expected event seen none", what);
        summarize();
    endtask : fail
    task do_reset(input logic boot);
        boot_mode_i <= boot;
        rst_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : do_reset
    task hwr(input hpw_idx_t idx, input logic [31:0] d);
        @(posedge sys_clk_i);
        u_idx_i <= idx;
        u_wdata_i <= d;
        u_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        u_wr_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask : hwr
    // Posts a write and returns at once, so that a read can follow with no gap.
    task hpost(input hpw_idx_t idx, input logic [31:0] d);
        @(posedge sys_clk_i);
        u_idx_i <= idx;
        u_wdata_i <= d;
        u_wr_i <= 1'b1;
    endtask : hpost
    task hrd(input hpw_idx_t idx);
        @(posedge sys_clk_i);
        u_idx_i <= idx;
        u_wr_i <= 1'b0;
        u_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        u_rd_i <= 1'b0;
        for (k = 0; k < 8; k++) begin
            #1;
            if (u_valid_o === 1'b1) break;
            @(posedge sys_clk_i);
        end
        if (k == 8) fail("host read valid");
        q = u_rdata_o;
    endtask : hrd
    task cwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        cpu_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        cpu_wr_i <= 1'b0;
    endtask : cwr
    task crd(input logic [7:0] a);
        @(posedge sys_clk_i);
        cpu_addr_i <= a;
        cpu_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        cpu_rd_i <= 1'b0;
        #1 q = cpu_rdata_o;
    endtask : crd
    // The address is left standing, so the read word does not depend on the exact lag.
    task cram(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        cpu_ram_req_i <= 1'b1;
        cpu_ram_we_i <= we;
        cpu_ram_addr_i <= a;
        cpu_ram_wdata_i <= d;
        @(posedge sys_clk_i);
        cpu_ram_req_i <= 1'b0;
        cpu_ram_we_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 q = cpu_ram_rdata_o;
    endtask : cram
    task see_wait(input logic v);
        for (k = 0; k < 8 && cpu_wait_o !== v; k++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (cpu_wait_o !== v) fail("cpu wait level");
        checks++;
    endtask : see_wait

    task t_regs;
        hrd(IDX_OUT_IRQ); chk("irq reset", 32'h0, q);
        hrd(IDX_PTR); chk("pointer reset", 32'h0, q);
        hrd(IDX_DATA); chk("data reset", 32'h0, q);
        hrd(IDX_GATE); chk("gate reset normal", 32'h0, q);
        $display("test registers done");
    endtask : t_regs
    task t_irq;
        hwr(IDX_OUT_IRQ, 32'hFFFF_FFFF);
        hrd(IDX_OUT_IRQ); chk("irq register", 32'h0000_00FF, q);
        chk("irq pin high", 32'h1, {31'h0, u_irq_o});
        cwr(CPU_OUT_IRQ, 32'h0000_0054);
        hrd(IDX_OUT_IRQ); chk("irq cpu write", 32'h0000_0054, q);
        // The pin crosses a three-stage synchroniser on the host side.
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("irq pin low", 32'h0, {31'h0, u_irq_o});
        $display("test interrupt done");
    endtask : t_irq
    task t_ptr_mail;
        hwr(IDX_PTR, 32'hFFFF_FFFF);
        hrd(IDX_PTR); chk("pointer mask", 32'h0000_03FC, q);
        cwr(CPU_PTR, 32'h0);
        crd(CPU_PTR); chk("pointer cpu write", 32'h0000_03FC, q);
        hwr(IDX_DATA, 32'hA5A5_5A5A);
        crd(CPU_DATA); chk("mailbox to cpu", 32'hA5A5_5A5A, q);
        cwr(CPU_DATA, 32'h1234_5678);
        hrd(IDX_DATA); chk("mailbox to host", 32'h1234_5678, q);
        $display("test pointer and mailbox done");
    endtask : t_ptr_mail
    task t_gate;
        cwr(CPU_GATE, 32'h0000_00A5);
        hrd(IDX_GATE); chk("gate cpu write", 32'h0, q);
        hwr(IDX_GATE, 32'h0000_0001);
        hrd(IDX_GATE); chk("gate without key", 32'h0, q);
        hwr(IDX_GATE, 32'h0000_00A5);
        hrd(IDX_GATE); chk("gate with key", 32'h1, q);
        @(posedge sys_clk_i);
        cpu_ram_req_i <= 1'b1;
        see_wait(1'b1);
        hwr(IDX_GATE, 32'h0);
        see_wait(1'b0);
        cpu_ram_req_i <= 1'b0;
        $display("test gate done");
    endtask : t_gate
    task t_b2b;
        hpost(IDX_OUT_IRQ, 32'h0000_0081);
        hrd(IDX_OUT_IRQ); chk("irq back to back", 32'h0000_0081, q);
        hpost(IDX_OUT_IRQ, 32'h0);
        hrd(IDX_OUT_IRQ); chk("irq clear back to back", 32'h0, q);
        hpost(IDX_PTR, 32'h0000_0124);
        hrd(IDX_PTR); chk("pointer back to back", 32'h0000_0124, q);
        hpost(IDX_GATE, 32'h0000_00A5);
        hrd(IDX_GATE); chk("gate key back to back", 32'h1, q);
        hpost(IDX_GATE, 32'h0000_00FE);
        hrd(IDX_GATE); chk("gate clear back to back", 32'h0, q);
        $display("test back to back done");
    endtask : t_b2b
    task t_consec;
        hwr(IDX_PTR, 32'h0000_03FC);
        hwr(IDX_MEMCMD, 32'h0000_0060);
        for (int i = 1; i <= 3; i++) hwr(IDX_DATA, 32'(i * 17));
        hwr(IDX_MEMCMD, 32'h0);
        hrd(IDX_PTR); chk("pointer after up steps", 32'h0000_0008, q);
        cram(1'b0, 8'hFF, 32'h0); chk("ram top word", 32'h0000_0011, q);
        cram(1'b0, 8'h01, 32'h0); chk("ram wrapped word", 32'h0000_0033, q);
        hwr(IDX_PTR, 32'h0000_0004);
        hwr(IDX_MEMCMD, 32'h0000_0061);
        hwr(IDX_DATA, 32'h0000_0044);
        hwr(IDX_DATA, 32'h0000_0055);
        hwr(IDX_MEMCMD, 32'h0);
        hrd(IDX_PTR); chk("pointer after down steps", 32'h0000_03FC, q);
        cram(1'b0, 8'h00, 32'h0); chk("ram down word", 32'h0000_0055, q);
        hwr(IDX_PTR, 32'h0000_03FC);
        hwr(IDX_MEMCMD, 32'h0000_0008);
        hwr(IDX_MEMCMD, 32'h0000_0048);
        hrd(IDX_DATA); chk("hold read first", 32'h0000_0011, q);
        hrd(IDX_DATA); chk("hold read next", 32'h0000_0055, q);
        hwr(IDX_MEMCMD, 32'h0);
        hrd(IDX_PTR); chk("pointer after hold reads", 32'h0000_0004, q);
        cram(1'b1, 8'h80, 32'h0000_0077);
        hwr(IDX_PTR, 32'h0000_0200);
        hwr(IDX_MEMCMD, 32'h0000_0008);
        hrd(IDX_DATA); chk("single fetch", 32'h0000_0077, q);
        $display("test consecutive done");
    endtask : t_consec
    task t_boot;
        do_reset(1'b1);
        hrd(IDX_GATE); chk("gate reset boot", 32'h1, q);
        hwr(IDX_PTR, 32'h0);
        hwr(IDX_DATA, 32'hCAFE_0001);
        hwr(IDX_MEMCMD, 32'h0000_0020);
        fork
            hwr(IDX_GATE, 32'h0);
            begin
                for (k = 0; k < 12 && cpu_boot_go_o !== 1'b1; k++) begin
                    @(posedge sys_clk_i);
                    #1;
                end
            end
        join
        if (k == 12) fail("boot start pulse");
        cram(1'b0, 8'h00, 32'h0); chk("boot word", 32'hCAFE_0001, q);
        $display("test boot done");
    endtask : t_boot

    // Main sequence: every scenario judges its own results before returning.
    initial begin
        do_reset(1'b0);
        t_regs();
        t_irq();
        t_ptr_mail();
        t_gate();
        t_b2b();
        t_consec();
        t_boot();
        summarize();
    end
endmodule : hpw_test
